// ### hw/jmc_mode_control.sv
// module: mode control, own tap and scan path steering of the jtag multiplexer
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module jmc_mode_control import jmc_pkg::*; #(
  parameter int PORTS = 7,
  parameter int SLOT_BITS = 8
) (
  // system clock and reset pin
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // strap pins
  input wire logic primaryModeSelectPin,
  input wire logic transparentSelectPin,
  input wire logic [PORTS-1:0] localPortSelectPins,
  input wire logic [SLOT_BITS-1:0] slotAddressPins,
  // backplane tap
  input wire logic tckB,
  input wire logic tmsB,
  input wire logic tdiB,
  input wire logic trstB_n,
  output logic tdoB,
  // local scan ports
  output logic [PORTS-1:0] localTck,
  output logic [PORTS-1:0] localTms,
  output logic [PORTS-1:0] localTdi,
  output logic [PORTS-1:0] localTrst_n,
  input wire logic [PORTS-1:0] localTdo
);
  // refuse port counts the 8-bit register fields cannot hold
  if (PORTS < 1 || PORTS > 7 || SLOT_BITS < 1 || SLOT_BITS > 8) begin : g_check
    $error("jmc_mode_control: PORTS must be 1..7 and SLOT_BITS 1..8");
  end

  localparam int SW = 4 + PORTS + 2 + PORTS + SLOT_BITS; // width of the synchroniser bank

  logic [SW-1:0] syncA; // first synchroniser stage, read only by syncB
  logic [SW-1:0] syncB; // second stage, the only copy logic may read
  logic tckSeen; // previous value of the synced test clock
  logic tckRise; // one-cycle strobe on a test clock rising edge
  logic tckS, tmsS, tdiS, trstS_n; // synced backplane lines
  logic [PORTS-1:0] tdoS; // synced local data returns
  logic primaryS, transS; // synced straps
  logic [PORTS-1:0] lpsS; // synced port-select straps
  logic [SLOT_BITS-1:0] slotS; // synced slot address

  // every strap, tap and local return signal passes two flops first; the bus signals do not
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {tckB, tmsB, tdiB, trstB_n, localTdo, primaryModeSelectPin,
                transparentSelectPin, localPortSelectPins, slotAddressPins};
      syncB <= syncA;
    end
  end
  assign {tckS, tmsS, tdiS, trstS_n, tdoS, primaryS, transS, lpsS, slotS} = syncB;

  // test clock edge finder
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tckSeen <= 1'b0;
    end else begin
      tckSeen <= tckS;
    end
  end
  assign tckRise = tckS & ~tckSeen;

  // configuration state
  logic primaryMode; // 1 bridge, 0 stitcher
  logic transparentSelect; // stored transparent-select bit
  logic externalResetMask; // masks backplane test reset and five-high reset
  logic fullTransparent; // committed full transparent mode
  logic pendingTrans; // written transparent bit awaiting update-dr
  logic [PORTS-1:0] localPortSelect; // stitcher port selection
  logic [7:0] mode0, mode1, mode2; // bridge mode registers
  logic [1:0] loadCnt; // counts synchroniser fill after reset
  logic strapLoad; // reload defaults from pins this cycle
  logic fiveHigh; // five-high tms sequence seen
  logic [2:0] highCnt; // consecutive tms-high test clocks
  logic fullReset; // complete reset of configuration
  logic tapForceReset; // own tap to reset without config loss
  jmc_tap_t tapState, next_tapState; // own tap controller
  logic [7:0] instr; // own instruction register
  logic [7:0] instrShift; // instruction shift stage
  logic ownBit; // one-bit internal data stage in the chain
  jmc_chain_t chainMode; // present scan chain mode
  logic [PORTS-1:0] selected; // unparked local ports
  logic busAck; // second cycle of a bus access
  logic busWrite; // write takes effect this cycle

  // count tms-high test clocks; the fifth one is a reset sequence
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      highCnt <= '0;
    end else if (tckRise) begin
      if (!tmsS) begin
        highCnt <= '0;
      end else if (highCnt != FIVE_HIGH_COUNT) begin
        highCnt <= highCnt + 3'h1;
      end
    end
  end
  assign fiveHigh = tckRise && tmsS && (highCnt == FIVE_HIGH_COUNT - 3'h1);

  // complete reset from test reset or five-high, both masked; transparent ignores five-high
  assign fullReset = !externalResetMask &&
                     (!trstS_n || (fiveHigh && !fullTransparent));
  // masked test reset still returns own tap to reset unless transparent
  assign tapForceReset = !trstS_n && externalResetMask && !fullTransparent;

  // straps become valid two cycles after release, so loading waits for the bank to fill
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loadCnt <= LOAD_DELAY;
    end else if (fullReset) begin
      loadCnt <= LOAD_DELAY;
    end else if (loadCnt != 2'h0) begin
      loadCnt <= loadCnt - 2'h1;
    end
  end
  assign strapLoad = (loadCnt == 2'h1);

  // own tap controller next state
  always_comb begin
    next_tapState = tapState;
    case (tapState)
      TAP_RESET: next_tapState = tmsS ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_tapState = tmsS ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tapState = tmsS ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tapState = tmsS ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_tapState = tmsS ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_tapState = tmsS ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_tapState = tmsS ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_tapState = tmsS ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR: next_tapState = tmsS ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tapState = tmsS ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_tapState = tmsS ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_tapState = tmsS ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_tapState = tmsS ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_tapState = tmsS ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_tapState = tmsS ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR: next_tapState = tmsS ? TAP_SEL_DR : TAP_IDLE;
      default: next_tapState = TAP_RESET;
    endcase
  end

  // own tap steps with the backplane tms; it stays put once transparent
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tapState <= TAP_RESET;
    end else if (fullReset || tapForceReset) begin
      tapState <= TAP_RESET;
    end else if (tckRise && !fullTransparent) begin
      tapState <= next_tapState;
    end
  end

  // instruction shift and update; decoding halts in full transparent
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instrShift <= INSTR_RESET;
      instr <= INSTR_RESET;
    end else if (fullReset || tapForceReset) begin
      instrShift <= INSTR_RESET;
      instr <= INSTR_RESET;
    end else if (tckRise && !fullTransparent) begin
      if (tapState == TAP_SHIFT_IR) begin
        instrShift <= {tdiS, instrShift[7:1]};
      end else if (tapState == TAP_UPDATE_IR) begin
        instr <= instrShift;
      end
    end
  end

  // one internal data bit stands in front of the local chains outside full transparent
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ownBit <= 1'b0;
    end else if (tckRise && !fullTransparent &&
                 (tapState == TAP_SHIFT_DR || tapState == TAP_SHIFT_IR)) begin
      ownBit <= tdiS;
    end
  end

  // bus handshake: every access answers in its second cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busAck <= 1'b0;
    end else begin
      busAck <= (avsRead || avsWrite) && !busAck;
    end
  end
  assign avsWaitrequest = (avsRead || avsWrite) && !busAck;
  assign busWrite = avsWrite && busAck;

  // control bits: primary and transparent from straps at reset, mask cleared; software writes refused in full transparent
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      primaryMode <= 1'b0;
      transparentSelect <= 1'b0;
      externalResetMask <= 1'b0;
      pendingTrans <= 1'b0;
    end else if (strapLoad || fullReset) begin
      primaryMode <= primaryS;
      transparentSelect <= transS;
      externalResetMask <= 1'b0;
      pendingTrans <= 1'b0;
    end else if (busWrite && avsAddress == ADDR_CONTROL && !fullTransparent) begin
      transparentSelect <= avsWritedata[CTRL_TRANSPARENT_BIT];
      externalResetMask <= avsWritedata[CTRL_MASK_BIT];
      pendingTrans <= avsWritedata[CTRL_TRANSPARENT_BIT] && !primaryMode;
    end else if (pendingTrans && tckRise && next_tapState == TAP_UPDATE_DR) begin
      pendingTrans <= 1'b0; // cleared on the very tck edge that enters update-dr
    end
  end

  // full transparent: entered from the pin in stitcher, or by a write at update-dr
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fullTransparent <= 1'b0;
    end else if (fullReset) begin
      fullTransparent <= 1'b0;
    end else if (strapLoad) begin
      fullTransparent <= transS && !primaryS;
    end else if (pendingTrans && tckRise && next_tapState == TAP_UPDATE_DR) begin
      // commit on the edge that enters update-dr, not one test clock later
      fullTransparent <= 1'b1;
    end
  end

  // port selection and mode registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      localPortSelect <= '0;
      mode0 <= MODE0_RESET;
      mode1 <= MODE_RESET;
      mode2 <= MODE_RESET;
    end else if (strapLoad || fullReset) begin
      localPortSelect <= lpsS;
      mode0 <= MODE0_RESET;
      mode1 <= MODE_RESET;
      mode2 <= MODE_RESET;
    end else if (busWrite && !fullTransparent) begin
      case (avsAddress)
        ADDR_LOCAL_PORT_SELECT: localPortSelect <= avsWritedata[PORTS-1:0];
        ADDR_MODE0: mode0 <= avsWritedata[7:0];
        ADDR_MODE1: mode1 <= avsWritedata[7:0];
        ADDR_MODE2: mode2 <= avsWritedata[7:0];
        default: ;
      endcase
    end
  end

  // chain mode and port choice follow the primary mode
  always_comb begin
    if (fullTransparent) begin
      chainMode = CHAIN_FULL_TRANSPARENT;
    end else if (primaryMode && mode0[MODE0_TRANSPARENT_SELECT_LOCAL_BIT]) begin
      chainMode = CHAIN_TRANSPARENT_LOCAL;
    end else begin
      chainMode = CHAIN_NORMAL;
    end
    selected = primaryMode ? mode0[PORTS-1:0] : localPortSelect;
  end

  // scan path: own bit, then each selected port, with its pad in normal mode; full transparent skips the own bit
  logic [PORTS:0] chainLink; // serial data between stages
  logic [PORTS-1:0] padReg; // pad bit after each port
  logic [PORTS-1:0] padUse; // which ports carry a pad now
  logic lastPad; // single pad after the final chain
  int lastIdx; // highest selected port

  always_comb begin
    lastIdx = -1;
    for (int i = 0; i < PORTS; i++) begin
      if (selected[i]) begin
        lastIdx = i;
      end
    end
    for (int i = 0; i < PORTS; i++) begin
      // pads: each chain in normal, none otherwise
      padUse[i] = selected[i] && (chainMode == CHAIN_NORMAL);
    end
  end
  // backplane data reaches the first port directly in full transparent
  assign chainLink[0] = fullTransparent ? tdiS : ownBit;

  // pad flops sample the port's return on each test clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      padReg <= '0;
      lastPad <= 1'b0;
    end else if (tckRise) begin
      padReg <= tdoS;
      lastPad <= chainLink[PORTS];
    end
  end

  for (genvar g = 0; g < PORTS; g++) begin : g_link
    // a parked port is bypassed, a selected one returns through its pad when used
    assign chainLink[g+1] = !selected[g] ? chainLink[g] :
                            (padUse[g] ? padReg[g] : tdoS[g]);
  end

  // local port pins, registered; parked ports idle with tms low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      localTck <= '0;
      localTms <= '0;
      localTdi <= '0;
      localTrst_n <= '1;
      tdoB <= 1'b0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        localTck[i] <= selected[i] ? tckS : 1'b0;
        localTms[i] <= selected[i] && tmsS;
        localTdi[i] <= chainLink[i];
        localTrst_n[i] <= !selected[i] || trstS_n;
      end
      // one pad after the last chain in transparent-local-port mode
      tdoB <= (chainMode == CHAIN_TRANSPARENT_LOCAL && lastIdx >= 0) ? lastPad :
              chainLink[PORTS];
    end
  end

  // read data, registered in the wait cycle and held for the answer cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avsReaddata <= '0;
    end else if (avsRead && !busAck) begin
      avsReaddata <= '0;
      case (avsAddress)
        ADDR_CONTROL: begin
          avsReaddata[CTRL_PRIMARY_BIT] <= primaryMode;
          avsReaddata[CTRL_TRANSPARENT_BIT] <= transparentSelect;
          avsReaddata[CTRL_MASK_BIT] <= externalResetMask;
        end
        ADDR_LOCAL_PORT_SELECT: avsReaddata[PORTS-1:0] <= localPortSelect;
        ADDR_MODE0: avsReaddata[7:0] <= mode0;
        ADDR_MODE1: avsReaddata[7:0] <= mode1;
        ADDR_MODE2: avsReaddata[7:0] <= mode2;
        ADDR_STATUS: begin
          avsReaddata[STAT_CHAIN_LSB +: 2] <= chainMode;
          avsReaddata[STAT_TAP_LSB +: 4] <= tapState;
          avsReaddata[STAT_PENDING_BIT] <= pendingTrans;
          avsReaddata[STAT_INSTR_LSB +: 8] <= instr;
          // slot address matters only in bridge mode
          avsReaddata[STAT_SLOT_LSB +: SLOT_BITS] <= primaryMode ? slotS : '0;
        end
        default: ;
      endcase
    end
  end
endmodule // jmc_mode_control

// ### hw/jmc_pkg.sv
// package: register map, field layout, reset values and enumerations of the mode control
package jmc_pkg;
  // register byte addresses on the avalon slave
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_LOCAL_PORT_SELECT = 5'h04;
  localparam logic [4:0] ADDR_MODE0 = 5'h08;
  localparam logic [4:0] ADDR_MODE1 = 5'h0c;
  localparam logic [4:0] ADDR_MODE2 = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  // control register fields
  localparam int CTRL_PRIMARY_BIT = 0;
  localparam int CTRL_TRANSPARENT_BIT = 1;
  localparam int CTRL_MASK_BIT = 2;
  // mode register 0 field that requests transparent-local-port mode in bridge mode
  localparam int MODE0_TRANSPARENT_SELECT_LOCAL_BIT = 7;
  // status register fields
  localparam int STAT_CHAIN_LSB = 0;
  localparam int STAT_TAP_LSB = 2;
  localparam int STAT_PENDING_BIT = 6;
  localparam int STAT_INSTR_LSB = 8;
  localparam int STAT_SLOT_LSB = 16;
  // reset values of the registers without a pin source
  localparam logic [7:0] MODE0_RESET = 8'h01;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] INSTR_RESET = 8'h00;
  // timing counts
  localparam logic [2:0] FIVE_HIGH_COUNT = 3'h5;
  localparam logic [1:0] LOAD_DELAY = 2'h3;
  // scan chain modes
  typedef enum logic [1:0] {
    CHAIN_NORMAL = 2'b00,
    CHAIN_FULL_TRANSPARENT = 2'b01,
    CHAIN_TRANSPARENT_LOCAL = 2'b10
  } jmc_chain_t;
  // tap controller states
  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000,
    TAP_IDLE = 4'b0001,
    TAP_SEL_DR = 4'b0010,
    TAP_CAP_DR = 4'b0011,
    TAP_SHIFT_DR = 4'b0100,
    TAP_EXIT1_DR = 4'b0101,
    TAP_PAUSE_DR = 4'b0110,
    TAP_EXIT2_DR = 4'b0111,
    TAP_UPDATE_DR = 4'b1000,
    TAP_SEL_IR = 4'b1001,
    TAP_CAP_IR = 4'b1010,
    TAP_SHIFT_IR = 4'b1011,
    TAP_EXIT1_IR = 4'b1100,
    TAP_PAUSE_IR = 4'b1101,
    TAP_EXIT2_IR = 4'b1110,
    TAP_UPDATE_IR = 4'b1111
  } jmc_tap_t;
endpackage

// ### sim/jmc_mode_control_chk.sv
// checker: port-level assertions of the jtag mode control
`timescale 1ns/1ps
module jmc_mode_control_chk import jmc_pkg::*; #(
  parameter int PORTS = 7,
  parameter int SLOT_BITS = 8
) (
  // clock, reset and bus
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  // straps and tap lines
  input wire logic primaryModeSelectPin,
  input wire logic [SLOT_BITS-1:0] slotAddressPins,
  input wire logic tckB,
  input wire logic trstB_n,
  input wire logic [PORTS-1:0] localTck
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic rdOk; // a read is answered in this cycle
  logic stRd; // that read targets status
  logic fullT; // last status read showed full transparent
  assign rdOk = avsRead && !avsWaitrequest;
  assign stRd = rdOk && (avsAddress == ADDR_STATUS);
  // track chain mode from status reads; any test reset may end it, so forget it then
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fullT <= 1'b0;
    end else if (!trstB_n) begin
      fullT <= 1'b0;
    end else if (stRd) begin
      fullT <= (avsReaddata[1:0] == CHAIN_FULL_TRANSPARENT);
    end
  end
  property p_wait_one;
    $rose(avsRead || avsWrite) |-> avsWaitrequest ##1 !avsWaitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait");
  property p_no_stall;
    !(avsRead || avsWrite) |-> !avsWaitrequest;
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("wait raised with no request");
  property p_unmapped;
    rdOk && (avsAddress == 5'h18) |-> avsReaddata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_primary_bit;
    rdOk && (avsAddress == ADDR_CONTROL) |-> avsReaddata[0] == primaryModeSelectPin;
  endproperty
  a_primary_bit: assert property (p_primary_bit) else $error("primary bit off pin");
  property p_slot;
    stRd |-> avsReaddata[23:16] == (primaryModeSelectPin ? slotAddressPins : 8'h00);
  endproperty
  a_slot: assert property (p_slot) else $error("slot field wrong");
  property p_bridge_chain;
    stRd && primaryModeSelectPin |-> avsReaddata[1:0] != CHAIN_FULL_TRANSPARENT;
  endproperty
  a_bridge_chain: assert property (p_bridge_chain) else $error("bridge took pin");
  property p_stitch_chain;
    stRd && !primaryModeSelectPin |-> avsReaddata[1:0] != CHAIN_TRANSPARENT_LOCAL;
  endproperty
  a_stitch_chain: assert property (p_stitch_chain) else $error("local mode in stitcher");
  property p_tck_follow;
    fullT && $rose(tckB) |-> ##[2:8] (|localTck);
  endproperty
  a_tck_follow: assert property (p_tck_follow) else $error("local clock not following");
endmodule // jmc_mode_control_chk

bind jmc_mode_control jmc_mode_control_chk #(.PORTS(PORTS), .SLOT_BITS(SLOT_BITS)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
  .primaryModeSelectPin(primaryModeSelectPin), .slotAddressPins(slotAddressPins),
  .tckB(tckB), .trstB_n(trstB_n), .localTck(localTck));

// ### sim/jmc_bp_ctrl.sv
// partner: backplane boundary scan controller on the test access port
`timescale 1ns/1ps
module jmc_bp_ctrl (
  // backplane tap lines
  output logic tckB,
  output logic tmsB,
  output logic tdiB,
  output logic trstB_n
);
  // idle: clock parked low outside frames, test reset released
  initial begin
    tckB = 1'b0;
    tmsB = 1'b1;
    tdiB = 1'b0;
    trstB_n = 1'b1;
  end
  // clock n tms bits lsb first, 64 ns period; off-grid start keeps it unrelated to clk_sys
  task automatic walk(input logic [7:0] tms, input int n, input logic tdi);
    #1.3;
    for (int i = 0; i < n; i++) begin
      tmsB = tms[i];
      tdiB = tdi;
      #32 tckB = 1'b1;
      #32 tckB = 1'b0;
    end
    // data line means nothing between frames, so it shows a changed level
    tdiB = ~tdi;
  endtask
  // drive the test reset line
  task automatic set_trst(input logic lvl);
    trstB_n = lvl;
  endtask
endmodule // jmc_bp_ctrl

// ### sim/jmc_mode_control_tb.sv
// testbench: mode control of the jtag multiplexer against a behavioural model
`timescale 1ns/1ps
module jmc_mode_control_tb import jmc_pkg::*; ;
  logic clk_sys = 1'b0; // system clock
  logic rst_n = 1'b0; // device reset pin
  logic [4:0] avsAddress = 5'h00; // bus master side
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic primaryModeSelectPin = 1'b0; // straps
  logic transparentSelectPin = 1'b0;
  logic [6:0] localPortSelectPins = 7'h01;
  logic [7:0] slotAddressPins = 8'h00;
  logic tckB, tmsB, tdiB, trstB_n, tdoB; // backplane tap
  logic [6:0] localTck, localTms, localTdi, localTrst_n;
  logic [6:0] localTdo = 7'h00; // target data outputs
  int err_total = 0;
  int comparisons = 0;
  int seed = 38;
  int cycles = 0;
  int mPrim, mTrans, mMask, mPorts, mPortReg, mSlot, mChain; // model state
  int f, l, v;
  logic [31:0] rd; // last read data
  always #2 clk_sys = ~clk_sys;
  jmc_mode_control dut (.clk_sys(clk_sys), .rst_n(rst_n), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .primaryModeSelectPin(primaryModeSelectPin), .transparentSelectPin(transparentSelectPin),
    .localPortSelectPins(localPortSelectPins), .slotAddressPins(slotAddressPins),
    .tckB(tckB), .tmsB(tmsB), .tdiB(tdiB), .trstB_n(trstB_n), .tdoB(tdoB),
    .localTck(localTck), .localTms(localTms), .localTdi(localTdi),
    .localTrst_n(localTrst_n), .localTdo(localTdo));
  jmc_bp_ctrl bp (.tckB(tckB), .tmsB(tmsB), .tdiB(tdiB), .trstB_n(trstB_n));
  // verdict and end of run
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      close_out();
    end
  end
  // compare a register word
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // compare a pin level
  task automatic cmp_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon access, entered right after a rising edge; held until waitrequest is low
  // at a rising edge; only the hang guard ends a wait that never comes
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    avsAddress <= a;
    avsWritedata <= wd;
    avsWrite <= wr;
    avsRead <= !wr;
    @(posedge clk_sys);
    while (avsWaitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk_sys);
  endtask
  // let synchronisers settle after link activity
  task automatic realign();
    repeat (10) @(posedge clk_sys);
  endtask
  // lowest or highest selected port
  function automatic int sel_idx(input int p, input bit last);
    int r;
    r = -1;
    for (int i = 0; i < 7; i++) if (p[i] && (last || r < 0)) r = i;
    return r;
  endfunction
  // model: every complete reset reloads straps
  task automatic model_reload();
    mTrans = transparentSelectPin;
    mMask = 0;
    mPortReg = mPorts;
    mChain = (mPrim == 0 && mTrans == 1);
  endtask
  // device reset with fresh straps
  task automatic do_reset(input int prim, input int transparent_select);
    mPorts = $random(seed) & 32'h7f;
    if (mPorts == 0) mPorts = 4;
    mSlot = $random(seed) & 32'hff;
    mPrim = prim;
    rst_n <= 1'b0;
    primaryModeSelectPin <= prim[0];
    transparentSelectPin <= transparent_select[0];
    localPortSelectPins <= mPorts[6:0];
    slotAddressPins <= mSlot[7:0];
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    model_reload();
  endtask
  // control write; refused once full transparent
  task automatic wr_ctrl(input int w);
    bus(1'b1, ADDR_CONTROL, 32'(w));
    if (mChain != 1) begin
      mTrans = (w >> 1) & 1;
      mMask = (w >> 2) & 1;
    end
  endtask
  // walk the taps from reset to update-dr
  task automatic to_update();
    bp.walk(8'h1a, 5, 1'b0);
    realign();
    if (mPrim == 0 && mTrans == 1) mChain = 1;
  endtask
  task automatic chk_ctrl();
    bus(1'b0, ADDR_CONTROL, 32'h0);
    cmp_word(rd & 32'h7, mPrim | (mTrans << 1) | (mMask << 2));
  endtask
  task automatic chk_ports();
    bus(1'b0, ADDR_LOCAL_PORT_SELECT, 32'h0);
    cmp_word(rd & 32'h7f, mPortReg);
  endtask
  task automatic chk_status();
    bus(1'b0, ADDR_STATUS, 32'h0);
    cmp_word(32'(rd[1:0]), mChain);
    cmp_word(32'(rd[STAT_PENDING_BIT]), (mPrim == 0 && mTrans == 1 && mChain == 0));
    cmp_word(32'(rd[23:16]), mPrim ? mSlot : 0);
  endtask
  initial begin
    @(posedge clk_sys);
    do_reset(0, 0);
    chk_ctrl();
    chk_ports();
    chk_status();
    bus(1'b1, ADDR_MODE0, 32'h80);
    chk_status();
    bus(1'b1, 5'h18, 32'hff);
    bus(1'b0, 5'h18, 32'h0);
    cmp_word(rd, 32'h0);
    v = $random(seed) & 32'h7f;
    bus(1'b1, ADDR_LOCAL_PORT_SELECT, 32'(v));
    mPortReg = v;
    chk_ports();
    bp.walk(8'h3f, 6, 1'b1);
    realign();
    model_reload();
    chk_ports();
    $display("test stitcher normal done");
    wr_ctrl(2);
    chk_status();
    to_update();
    chk_status();
    bus(1'b1, ADDR_LOCAL_PORT_SELECT, 32'h0);
    chk_ports();
    wr_ctrl(0);
    chk_ctrl();
    f = sel_idx(mPortReg, 1'b0);
    l = sel_idx(mPortReg, 1'b1);
    for (int k = 0; k < 2; k++) begin
      bp.walk(8'h00, 1, k[0]);
      localTdo <= 7'($random(seed));
      realign();
      cmp_pin(localTdi[f], tdiB);
      cmp_pin(tdoB, localTdo[l]);
      cmp_pin(localTms[f], tmsB);
    end
    bp.walk(8'h3f, 6, 1'b1);
    realign();
    chk_status();
    bp.set_trst(1'b0);
    realign();
    bp.set_trst(1'b1);
    realign();
    model_reload();
    chk_status();
    $display("test stitcher transparent done");
    wr_ctrl(4);
    wr_ctrl(6);
    chk_ctrl();
    to_update();
    chk_status();
    bp.set_trst(1'b0);
    realign();
    cmp_pin(localTrst_n[sel_idx(mPortReg, 1'b0)], 1'b0);
    bp.set_trst(1'b1);
    realign();
    chk_status();
    do_reset(0, 1);
    chk_status();
    chk_ctrl();
    chk_ports();
    $display("test masked reset done");
    do_reset(1, 1);
    chk_ctrl();
    chk_status();
    wr_ctrl(2);
    to_update();
    chk_status();
    bus(1'b0, ADDR_MODE0, 32'h0);
    cmp_word(rd & 32'hff, 32'(MODE0_RESET));
    bus(1'b1, ADDR_MODE1, 32'h5a);
    bus(1'b0, ADDR_MODE1, 32'h0);
    cmp_word(rd & 32'hff, 32'h5a);
    $display("test bridge done");
    close_out();
  end
endmodule // jmc_mode_control_tb
